// file: rdc_top.sv
// Receiver presence probe control with register port and interrupt
`timescale 1ns/1ps
`include "rdc_regs.svh"
module rdc_top
    import rdc_pkg::*;
#(
    parameter int CHARGE_CYC = `RDC_CHARGE_CYC,
    parameter int SETTLE_CYC = `RDC_SETTLE_CYC,
    parameter int TRANS_CYC  = `RDC_PWR_TRANS_CYC
) (
    input  wire logic                   sys_clk_in,
    input  wire logic                   arst_n_in,

    // Controller handshake
    input  wire logic                   rx_presence_probe_request_in,
    input  wire rdc_pwr_code_t          tx_power_state_in,
    input  wire rdc_pwr_code_t          rx_power_state_in,
    input  wire logic                   rate_select_in,
    output logic                        phy_completion_pulse_out,
    output rdc_status_code_t            rx_status_code_out,

    // Analog probe front end
    input  wire logic                   probe_level_low_in,
    output logic                        probe_drive_common_out,

    // Register port
    input  wire logic [`RDC_ADDR_W-1:0] reg_addr_in,
    input  wire logic [31:0]            reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    output logic [31:0]                 reg_rdata_out,
    output logic                        irq_out
);

    localparam int CW = `RDC_CNT_W;
    localparam int IW = `RDC_INT_W;

    // ------------------------------------------------------------
    // Power state tracking
    // ------------------------------------------------------------
    rdc_pwr_code_t pwr_state;
    logic          pwr_busy;
    logic          pwr_done;
    logic          pwr_mismatch;

    rdc_power_ctrl #(
        .TRANS_CYC         (TRANS_CYC)
    ) u_power (
        .sys_clk_in        (sys_clk_in),
        .arst_n_in         (arst_n_in),
        .tx_power_state_in (tx_power_state_in),
        .rx_power_state_in (rx_power_state_in),
        .rate_select_in    (rate_select_in),
        .cur_state_out     (pwr_state),
        .busy_out          (pwr_busy),
        .done_out          (pwr_done),
        .mismatch_out      (pwr_mismatch)
    );

    // ------------------------------------------------------------
    // Register file state
    // ------------------------------------------------------------
    logic          enable_q;
    logic          enable_d;

    logic [CW-1:0] settle_q;
    logic [CW-1:0] settle_d;

    logic [IW-1:0] int_q;
    logic [IW-1:0] int_d;

    logic [IW-1:0] mask_q;
    logic [IW-1:0] mask_d;

    logic [31:0]   rdata_q;
    logic [31:0]   rdata_d;

    logic          irq_q;
    logic          irq_d;

    logic          mis_prev_q;
    logic          mis_prev_d;

    // ------------------------------------------------------------
    // Probe sequencer state
    // ------------------------------------------------------------
    rdc_probe_state_t st_q;
    rdc_probe_state_t st_d;

    rdc_status_code_t code_q;
    rdc_status_code_t code_d;

    rdc_status_code_t last_q;
    rdc_status_code_t last_d;

    logic             cpl_q;
    logic             cpl_d;

    logic             drive_q;
    logic             drive_d;

    logic             tmr_start;
    logic [CW-1:0]    tmr_load;
    logic             tmr_abort;
    logic             tmr_busy;
    logic             tmr_expire;

    logic             probe_ok;
    logic             bad_req;

    rdc_delay_timer #(
        .W          (CW)
    ) u_timer (
        .sys_clk_in (sys_clk_in),
        .arst_n_in  (arst_n_in),
        .start_in   (tmr_start),
        .load_in    (tmr_load),
        .abort_in   (tmr_abort),
        .busy_out   (tmr_busy),
        .expire_out (tmr_expire)
    );

    // Probing only from a settled P1 with matching inputs
    assign probe_ok = enable_q && !pwr_busy && !pwr_mismatch &&
                      (pwr_state == `RDC_PWR_P1);

    // ------------------------------------------------------------
    // Probe sequencer
    // ------------------------------------------------------------
    // Charge the line, release, wait, then compare the level
    always_comb begin
        st_d      = st_q;
        code_d    = `RDC_CODE_ABSENT;
        last_d    = last_q;
        cpl_d     = 1'b0;
        drive_d   = 1'b0;
        tmr_start = 1'b0;
        tmr_load  = CW'(CHARGE_CYC);
        tmr_abort = 1'b0;
        bad_req   = 1'b0;
        case (st_q)
            PRB_IDLE: begin
                if (rx_presence_probe_request_in) begin
                    if (probe_ok) begin
                        st_d      = PRB_CHARGE;
                        drive_d   = 1'b1;
                        tmr_start = 1'b1;
                    end else begin
                        // Refused; held until the request drops
                        bad_req = 1'b1;
                        st_d    = PRB_WAIT_DROP;
                    end
                end
            end

            PRB_CHARGE: begin
                drive_d = 1'b1;
                if (pwr_busy) begin
                    tmr_abort = 1'b1;
                    st_d      = PRB_WAIT_DROP;
                end else if (tmr_expire) begin
                    drive_d   = 1'b0;
                    tmr_start = 1'b1;
                    tmr_load  = settle_q;
                    st_d      = PRB_SETTLE;
                end
            end

            PRB_SETTLE: begin
                if (pwr_busy) begin
                    // Power change mid-probe ends it unreported
                    tmr_abort = 1'b1;
                    st_d      = PRB_WAIT_DROP;
                end else if (tmr_expire) begin
                    st_d = PRB_REPORT;
                end
            end

            PRB_REPORT: begin
                // Slow rise means a terminated far receiver
                code_d = probe_level_low_in ? `RDC_CODE_PRESENT
                                            : `RDC_CODE_ABSENT;
                last_d = code_d;
                cpl_d  = 1'b1;
                st_d   = PRB_WAIT_DROP;
            end

            PRB_WAIT_DROP: begin
                // One probe per request; wait for it to fall
                if (!rx_presence_probe_request_in) begin
                    st_d = PRB_IDLE;
                end
            end

            default: begin
                st_d = PRB_IDLE;
            end
        endcase

        // Power and rate completion share the pulse
        if (pwr_done) begin
            cpl_d = 1'b1;
        end
    end

    // Sequencer registers; outputs come straight from flops
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q    <= PRB_IDLE;
            code_q  <= `RDC_CODE_ABSENT;
            last_q  <= `RDC_CODE_ABSENT;
            cpl_q   <= 1'b0;
            drive_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            code_q  <= code_d;
            last_q  <= last_d;
            cpl_q   <= cpl_d;
            drive_q <= drive_d;
        end
    end

    // Pulse lasts one cycle, code beside it
    assign phy_completion_pulse_out = cpl_q;
    assign rx_status_code_out       = code_q;
    assign probe_drive_common_out   = drive_q;

    // ------------------------------------------------------------
    // Register port and interrupt
    // ------------------------------------------------------------
    // Writes, read data and sticky events; set beats clear
    always_comb begin
        logic [IW-1:0] ev;
        ev         = '0;
        enable_d   = enable_q;
        settle_d   = settle_q;
        mask_d     = mask_q;
        int_d      = int_q;
        rdata_d    = 32'h0;
        mis_prev_d = pwr_mismatch;

        ev[`RDC_INT_PROBE_DONE] = (st_q == PRB_REPORT);
        ev[`RDC_INT_POWER_DONE] = pwr_done;
        ev[`RDC_INT_BAD_REQ]    = bad_req;
        ev[`RDC_INT_MISMATCH]   = pwr_mismatch && !mis_prev_q;

        // Register writes
        if (reg_wr_in) begin
            case (reg_addr_in)
                `RDC_REG_CTRL:      enable_d = reg_wdata_in[0];
                `RDC_REG_PROBE_CFG: settle_d = reg_wdata_in[CW-1:0];
                `RDC_REG_INT_MASK:  mask_d   = reg_wdata_in[IW-1:0];
                default:            enable_d = enable_q;
            endcase
        end

        // Reads answer next cycle
        if (reg_rd_in) begin
            case (reg_addr_in)
                `RDC_REG_CTRL:      rdata_d = {31'h0, enable_q};
                `RDC_REG_PROBE_CFG: rdata_d = {{(32-CW){1'b0}}, settle_q};
                `RDC_REG_STATUS:    rdata_d = {24'h0, pwr_mismatch,
                                               last_q, st_q != PRB_IDLE,
                                               pwr_busy, pwr_state};
                `RDC_REG_INT_STATUS: begin
                    rdata_d = {{(32-IW){1'b0}}, int_q};
                    int_d   = '0;
                end
                `RDC_REG_INT_MASK:  rdata_d = {{(32-IW){1'b0}}, mask_q};
                default:            rdata_d = 32'h0;
            endcase
        end

        // Events merge last
        int_d = int_d | ev;
        irq_d = |(int_d & mask_d);
    end

    // Register file flops
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            enable_q   <= `RDC_CTRL_RESET;
            settle_q   <= CW'(SETTLE_CYC);
            mask_q     <= `RDC_INT_MASK_RESET;
            int_q      <= '0;
            rdata_q    <= 32'h0;
            irq_q      <= 1'b0;
            mis_prev_q <= 1'b0;
        end else begin
            enable_q   <= enable_d;
            settle_q   <= settle_d;
            mask_q     <= mask_d;
            int_q      <= int_d;
            rdata_q    <= rdata_d;
            irq_q      <= irq_d;
            mis_prev_q <= mis_prev_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign irq_out       = irq_q;

endmodule : rdc_top

// file: rdc_regs.svh
// Constants for the receiver detect control block
`ifndef RDC_REGS_SVH
`define RDC_REGS_SVH

// ----------------------------------------------------------------
// Power state codes
// ----------------------------------------------------------------
`define RDC_PWR_P0          2'h0
`define RDC_PWR_P0S         2'h1
`define RDC_PWR_P1          2'h2
`define RDC_PWR_P2          2'h3
`define RDC_PWR_RESET       2'h2

// ----------------------------------------------------------------
// Detection result codes
// ----------------------------------------------------------------
`define RDC_CODE_ABSENT     3'h0
`define RDC_CODE_PRESENT    3'h3

// ----------------------------------------------------------------
// Register byte addresses and fields
// ----------------------------------------------------------------
`define RDC_ADDR_W          8
`define RDC_REG_CTRL        8'h00
`define RDC_REG_PROBE_CFG   8'h04
`define RDC_REG_STATUS      8'h08
`define RDC_REG_INT_STATUS  8'h0C
`define RDC_REG_INT_MASK    8'h10
`define RDC_CTRL_ENABLE     0
`define RDC_CTRL_RESET      1'h1
`define RDC_INT_W           4
`define RDC_INT_PROBE_DONE  0
`define RDC_INT_POWER_DONE  1
`define RDC_INT_BAD_REQ     2
`define RDC_INT_MISMATCH    3
`define RDC_INT_MASK_RESET  4'h0

// ----------------------------------------------------------------
// Timing: clock rate and phase times, cycles derived
// ----------------------------------------------------------------
`define RDC_CLK_MHZ         40
`define RDC_CNT_W           16
`define RDC_CHARGE_NS       1000
`define RDC_SETTLE_NS       10000
`define RDC_PWR_TRANS_NS    500
`define RDC_CHARGE_CYC      ((`RDC_CHARGE_NS * `RDC_CLK_MHZ + 999) / 1000)
`define RDC_SETTLE_CYC      ((`RDC_SETTLE_NS * `RDC_CLK_MHZ + 999) / 1000)
`define RDC_PWR_TRANS_CYC   ((`RDC_PWR_TRANS_NS * `RDC_CLK_MHZ + 999) / 1000)

`endif

// file: rdc_pkg.sv
// Types shared by the receiver detect control block
package rdc_pkg;

    typedef logic [1:0] rdc_pwr_code_t;
    typedef logic [2:0] rdc_status_code_t;

    typedef enum logic [2:0] {
        PRB_IDLE,
        PRB_CHARGE,
        PRB_SETTLE,
        PRB_REPORT,
        PRB_WAIT_DROP
    } rdc_probe_state_t;

endpackage : rdc_pkg

// file: rdc_delay_timer.sv
// Reloadable down counter giving a one-cycle expiry pulse
`timescale 1ns/1ps
module rdc_delay_timer #(
    parameter int W = 16
) (
    input  wire logic         sys_clk_in,
    input  wire logic         arst_n_in,
    input  wire logic         start_in,
    input  wire logic [W-1:0] load_in,
    input  wire logic         abort_in,
    output logic              busy_out,
    output logic              expire_out
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         exp_q;
    logic         exp_d;

    // Next count; a zero load still takes one cycle
    always_comb begin
        cnt_d = cnt_q;
        exp_d = 1'b0;
        if (abort_in) begin
            cnt_d = '0;
        end else if (start_in) begin
            cnt_d = (load_in == '0) ? W'(1) : load_in;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
            exp_d = (cnt_q == W'(1));
        end
    end

    // Count registers
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q <= '0;
            exp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end

    assign busy_out   = (cnt_q != '0);
    assign expire_out = exp_q;

endmodule : rdc_delay_timer

// file: rdc_power_ctrl.sv
// Power state and rate change tracker with completion pulse
`timescale 1ns/1ps
`include "rdc_regs.svh"
module rdc_power_ctrl
    import rdc_pkg::*;
#(
    parameter int TRANS_CYC = `RDC_PWR_TRANS_CYC
) (
    input  wire logic          sys_clk_in,
    input  wire logic          arst_n_in,
    input  wire rdc_pwr_code_t tx_power_state_in,
    input  wire rdc_pwr_code_t rx_power_state_in,
    input  wire logic          rate_select_in,
    output rdc_pwr_code_t      cur_state_out,
    output logic               busy_out,
    output logic               done_out,
    output logic               mismatch_out
);

    localparam logic [15:0] TRANS_LOAD = 16'(TRANS_CYC);

    rdc_pwr_code_t cur_q;
    rdc_pwr_code_t cur_d;
    logic          rate_q;
    logic          rate_d;
    logic [15:0]   cnt_q;
    logic [15:0]   cnt_d;
    logic          done_q;
    logic          done_d;
    logic          mis_q;
    logic          mis_d;

    // Latch a new state or rate, then time the transition
    always_comb begin
        cur_d  = cur_q;
        rate_d = rate_q;
        cnt_d  = cnt_q;
        done_d = 1'b0;
        mis_d  = (tx_power_state_in != rx_power_state_in);
        if (cnt_q != 16'h0) begin
            cnt_d  = cnt_q - 16'h1;
            done_d = (cnt_q == 16'h1);
        end else if (tx_power_state_in != cur_q ||
                     rate_select_in != rate_q) begin
            // TX code is the master copy of the power state
            cur_d  = tx_power_state_in;
            rate_d = rate_select_in;
            cnt_d  = (TRANS_LOAD == 16'h0) ? 16'h1 : TRANS_LOAD;
        end
    end

    // Tracker registers; lane wakes up assumed in P1
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cur_q  <= `RDC_PWR_RESET;
            rate_q <= 1'b0;
            cnt_q  <= 16'h0;
            done_q <= 1'b0;
            mis_q  <= 1'b0;
        end else begin
            cur_q  <= cur_d;
            rate_q <= rate_d;
            cnt_q  <= cnt_d;
            done_q <= done_d;
            mis_q  <= mis_d;
        end
    end

    assign cur_state_out = cur_q;
    assign busy_out      = (cnt_q != 16'h0);
    assign done_out      = done_q;
    assign mismatch_out  = mis_q;

endmodule : rdc_power_ctrl

// file: rdc_top_chk.sv
// Checker for the receiver presence probe control ports
`timescale 1ns/1ps
`include "rdc_regs.svh"
module rdc_top_chk
    import rdc_pkg::*;
#(
    parameter int CHARGE_CYC = 3,
    parameter int SETTLE_CYC = 5,
    parameter int TRANS_CYC  = 4
) (
    input wire logic                   sys_clk_in,
    input wire logic                   arst_n_in,
    input wire logic                   rx_presence_probe_request_in,
    input wire rdc_pwr_code_t          tx_power_state_in,
    input wire rdc_pwr_code_t          rx_power_state_in,
    input wire logic                   rate_select_in,
    input wire logic                   phy_completion_pulse_out,
    input wire rdc_status_code_t       rx_status_code_out,
    input wire logic                   probe_level_low_in,
    input wire logic                   probe_drive_common_out,
    input wire logic [`RDC_ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0]            reg_wdata_in,
    input wire logic                   reg_wr_in,
    input wire logic                   reg_rd_in,
    input wire logic [31:0]            reg_rdata_out,
    input wire logic                   irq_out
);
    localparam int PWR_LAT = TRANS_CYC + 2;
    logic [15:0]   drv_q, drv_d, quiet_q, quiet_d;
    rdc_pwr_code_t prev_q;
    logic          rate_q;

    // Charge length and quiet time since the last power or rate change or probe request
    always_comb begin
        drv_d = probe_drive_common_out ? drv_q + 16'h1 : 16'h0;
        quiet_d = (quiet_q == 16'hFF) ? quiet_q : quiet_q + 16'h1;
        if (tx_power_state_in != prev_q || rate_select_in != rate_q ||
            rx_presence_probe_request_in)
            quiet_d = 16'h0;
    end

    // Helper registers
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            drv_q <= 16'h0;
            quiet_q <= 16'h0;
            prev_q <= `RDC_PWR_RESET;
            rate_q <= 1'b0;
        end else begin
            drv_q <= drv_d;
            quiet_q <= quiet_d;
            prev_q <= tx_power_state_in;
            rate_q <= rate_select_in;
        end
    end

    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    // Read of the event bits with no completion close by
    sequence s_clear_read;
        reg_rd_in && reg_addr_in == `RDC_REG_INT_STATUS &&
        !phy_completion_pulse_out ##1 !phy_completion_pulse_out;
    endsequence

    a_pulse_single: assert property (
        phy_completion_pulse_out |=> !phy_completion_pulse_out)
        else $error("completion pulse longer than one cycle");
    a_code_quiet: assert property (
        !phy_completion_pulse_out |-> rx_status_code_out == 3'h0)
        else $error("status code set outside the pulse");
    a_code_legal: assert property (
        phy_completion_pulse_out |-> rx_status_code_out inside
        {`RDC_CODE_ABSENT, `RDC_CODE_PRESENT})
        else $error("illegal status code on the pulse");
    a_present_cause: assert property (
        phy_completion_pulse_out && rx_status_code_out == 3'h3
        |-> $past(probe_level_low_in))
        else $error("present reported without a slow line");
    a_drive_cause: assert property (
        $rose(probe_drive_common_out) |-> $past(rx_presence_probe_request_in))
        else $error("charge started without a request");
    a_charge_len: assert property (
        $fell(probe_drive_common_out) && $stable(tx_power_state_in)
        |-> drv_q == CHARGE_CYC + 1)
        else $error("charge phase of wrong length");
    a_power_lat: assert property (
        $changed(tx_power_state_in) && quiet_q >= PWR_LAT
        |-> ##PWR_LAT phy_completion_pulse_out)
        else $error("power change not completed in time");
    a_rdata_idle: assert property (
        !$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data outside the read answer cycle");
    a_irq_clear: assert property (
        s_clear_read |-> !irq_out)
        else $error("interrupt stays after the clearing read");
endmodule : rdc_top_chk

bind rdc_top rdc_top_chk #(.CHARGE_CYC(CHARGE_CYC),
    .SETTLE_CYC(SETTLE_CYC), .TRANS_CYC(TRANS_CYC)) i_rdc_top_chk (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .rx_presence_probe_request_in(rx_presence_probe_request_in),
    .tx_power_state_in(tx_power_state_in),
    .rx_power_state_in(rx_power_state_in), .rate_select_in(rate_select_in),
    .phy_completion_pulse_out(phy_completion_pulse_out),
    .rx_status_code_out(rx_status_code_out),
    .probe_level_low_in(probe_level_low_in),
    .probe_drive_common_out(probe_drive_common_out),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .irq_out(irq_out));

// file: rdc_ctrl_model.sv
// Controller model: probe requests and shared power codes
`timescale 1ns/1ps
module rdc_ctrl_model
    import rdc_pkg::*;
(
    input  wire logic             sys_clk_in,
    input  wire logic             arst_n_in,
    input  wire rdc_pwr_code_t    pwr_cmd_in,
    input  wire logic             skew_in,
    input  wire logic             go_in,
    input  wire logic             drop_in,
    input  wire logic             done_in,
    input  wire rdc_status_code_t code_in,
    output logic                  request_out,
    output rdc_pwr_code_t         tx_pwr_out,
    output rdc_pwr_code_t         rx_pwr_out,
    output rdc_status_code_t      result_out
);
    logic             req_q, req_d;
    rdc_status_code_t res_q, res_d;

    // One source feeds both codes; skew only when a test asks for it
    assign tx_pwr_out = pwr_cmd_in;
    assign rx_pwr_out = pwr_cmd_in ^ {1'b0, skew_in};
    assign request_out = req_q;
    assign result_out = res_q;

    // Request held until the pulse, result taken in that cycle
    always_comb begin
        req_d = req_q;
        res_d = res_q;
        if (go_in)
            req_d = 1'b1;
        if (req_q && done_in) begin
            res_d = code_in;
            req_d = 1'b0;
        end
        if (drop_in)
            req_d = 1'b0;
    end

    // Registers
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            req_q <= 1'b0;
            res_q <= 3'h0;
        end else begin
            req_q <= req_d;
            res_q <= res_d;
        end
    end
endmodule : rdc_ctrl_model

// file: testbench.sv
// Self-checking bench for the receiver presence probe control
`timescale 1ns/1ps
`include "rdc_regs.svh"
module testbench
    import rdc_pkg::*;
;
    localparam int C = 3;
    localparam int S = 5;
    localparam int T = 4;
    logic             sys_clk_in, arst_n_in, req, rate, lvl, drive;
    logic             wr, rd, irq, done, skew, go, drop;
    logic [7:0]       addr;
    logic [31:0]      wdata, rdata;
    rdc_pwr_code_t    pwr, txp, rxp;
    rdc_status_code_t code, res, last;
    int               n_errors, comparisons, cyc, hits;

    rdc_top #(.CHARGE_CYC(C), .SETTLE_CYC(S), .TRANS_CYC(T)) i_rdc_top (
        .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
        .rx_presence_probe_request_in(req), .tx_power_state_in(txp),
        .rx_power_state_in(rxp), .rate_select_in(rate),
        .phy_completion_pulse_out(done), .rx_status_code_out(code),
        .probe_level_low_in(lvl), .probe_drive_common_out(drive),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq));

    rdc_ctrl_model i_rdc_ctrl_model (
        .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .pwr_cmd_in(pwr),
        .skew_in(skew), .go_in(go), .drop_in(drop), .done_in(done),
        .code_in(code), .request_out(req), .tx_pwr_out(txp),
        .rx_pwr_out(rxp), .result_out(res));

    // 40 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    // Hang guard: a run of this size needs a few hundred cycles
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data is taken only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        @(negedge sys_clk_in);
        check(rdata, e);
    endtask : rd_chk

    // Counts settled cycles up to the completion pulse, bounded
    task automatic wait_done(input int exp);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk_in);
            n++;
        end while (done !== 1'b1 && n < 200);
        check(32'(n), 32'(exp));
    endtask : wait_done

    task automatic pulse_go();
        @(posedge sys_clk_in);
        go <= 1'b1;
        @(posedge sys_clk_in);
        go <= 1'b0;
    endtask : pulse_go

    task automatic probe(input logic [15:0] s, input logic present);
        rdc_status_code_t e;
        e = present ? `RDC_CODE_PRESENT : `RDC_CODE_ABSENT;
        wr_reg(`RDC_REG_PROBE_CFG, {16'h0, s});
        lvl <= present;
        pulse_go();
        wait_done(C + ((s == 16'h0) ? 1 : int'(s)) + 5);
        check(32'(code), 32'(e));
        @(negedge sys_clk_in);
        check(32'(done), 32'h0);
        check(32'(res), 32'(e));
        check(32'(irq), 32'h1);
        last = e;
        rd_chk(`RDC_REG_INT_STATUS, 32'h1);
        rd_chk(`RDC_REG_STATUS, {24'h0, 1'b0, e, 4'h2});
        check(32'(irq), 32'h0);
    endtask : probe

    // Power or rate change; its event bit is masked off
    task automatic link(input rdc_pwr_code_t p, input logic r);
        repeat (8) @(posedge sys_clk_in);
        pwr <= p;
        rate <= r;
        wait_done(T + 3);
        check(32'(code), 32'h0);
        @(negedge sys_clk_in);
        check(32'(irq), 32'h0);
        rd_chk(`RDC_REG_STATUS, {24'h0, 1'b0, last, 2'b00, p});
        rd_chk(`RDC_REG_INT_STATUS, 32'h2);
    endtask : link

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        arst_n_in = 1'b0;
        pwr = `RDC_PWR_P1;
        {wr, rd, go, drop, skew, rate, lvl} = 7'h0;
        {addr, wdata, last} = '0;
        void'($urandom(32'hCEE5));
        repeat (5) @(posedge sys_clk_in);
        check(32'({done, code, drive, irq}), 32'h0);
        arst_n_in <= 1'b1;
        rd_chk(`RDC_REG_CTRL, 32'h1);
        rd_chk(`RDC_REG_INT_MASK, 32'h0);
        rd_chk(`RDC_REG_STATUS, 32'h2);
        rd_chk(8'h14, 32'h0);
        wr_reg(`RDC_REG_INT_MASK, 32'h1);
        $display("reset test done");
        for (int i = 0; i < 6; i++)
            probe(i < 2 ? 16'(i) : 16'($urandom_range(1, 12)),
                  1'($urandom_range(0, 1)) | (i == 0));
        $display("probe test done");
        link(`RDC_PWR_P0S, 1'b0);
        link(`RDC_PWR_P2, 1'b0);
        link(`RDC_PWR_P0, 1'b0);
        $display("power test done");
        // Request outside P1 gives no pulse, only the refusal event
        hits = 0;
        pulse_go();
        repeat (40) begin
            @(negedge sys_clk_in);
            if (done === 1'b1)
                hits++;
        end
        check(32'(hits), 32'h0);
        rd_chk(`RDC_REG_INT_STATUS, 32'h4);
        @(posedge sys_clk_in);
        drop <= 1'b1;
        @(posedge sys_clk_in);
        drop <= 1'b0;
        link(`RDC_PWR_P1, 1'b0);
        link(`RDC_PWR_P1, 1'b1);
        link(`RDC_PWR_P1, 1'b0);
        $display("refusal and rate test done");
        @(posedge sys_clk_in);
        skew <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        rd_chk(`RDC_REG_STATUS, {24'h0, 1'b1, last, 4'h2});
        rd_chk(`RDC_REG_INT_STATUS, 32'h8);
        @(posedge sys_clk_in);
        skew <= 1'b0;
        $display("mismatch test done");
        wrap_up();
    end
endmodule : testbench
